/* src/clock_gate_pkg.sv */
package clock_gate_pkg;

	// Network shape
	localparam int SRC_COUNT = 16;
	localparam int QUAD_COUNT = 4;
	localparam int QUAD_CLOCKS = 16;
	localparam int SELECTOR_COUNT = 2;
	localparam int SELECTOR_INPUTS = 2;
	localparam int POOL_W = $clog2(SRC_COUNT + 1);
	localparam int ROUTE_W = $clog2(SRC_COUNT + SELECTOR_COUNT);

	// Values after reset, and synchronizer depth
	localparam logic RESET_LEVEL = 1'b0;
	localparam logic RESET_PICK = 1'b0;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		MODE_GLITCHLESS_LOW = 2'h0,
		MODE_GLITCHLESS_HIGH = 2'h1,
		MODE_PLAIN_MUX = 2'h2
	} selector_mode_type;

	localparam selector_mode_type DEFAULT_MODE = MODE_GLITCHLESS_LOW;

	typedef enum logic [2:0] {
		SEL_RUN = 3'h1,
		SEL_DRAIN = 3'h2,
		SEL_HANDOVER = 3'h4
	} selector_state_type;

	// One selector's settings from fabric and configuration
	typedef struct packed {
		logic [POOL_W-1:0] srcA;
		logic [POOL_W-1:0] srcB;
		logic pick;
		selector_mode_type mode;
	} selector_cfg_type;

endpackage

/* src/quadrant_clock_gate_and_select.sv */
// Functional notes
// - Disabled gate holds output static, no toggling.
// - Gate switches only at low level.
// - One gate per middle switch output.
// - Four quadrants, sixteen clocks each.
// - Each selector picks one of two clocks.
// - Glitchless handover when select changes, except in plain mux mode.
// - Plain mux passes clock even if stopped.
// - Mode per selector, glitchless-low by default.
// - Two selectors feeding the central switch.
`timescale 1ns/1ps
`default_nettype none

module quadrant_clock_gate_and_select #(
	parameter int SRC_COUNT = clock_gate_pkg::SRC_COUNT,
	parameter int QUAD_COUNT = clock_gate_pkg::QUAD_COUNT,
	parameter int QUAD_CLOCKS = clock_gate_pkg::QUAD_CLOCKS
) (
	// System
	input wire logic sys_clk,
	input wire logic rst_b,
	// Middle clock switch outputs and fabric clock entry
	input wire logic [SRC_COUNT-1:0] midClk,
	input wire logic fabricClockEntry,
	// Fabric control
	input wire logic [SRC_COUNT-1:0] gateEnable,
	input wire clock_gate_pkg::selector_cfg_type [clock_gate_pkg::SELECTOR_COUNT-1:0] selCfg,
	input wire logic [QUAD_COUNT-1:0][QUAD_CLOCKS-1:0][clock_gate_pkg::ROUTE_W-1:0] quadRoute,
	// Clock networks
	output logic [SRC_COUNT-1:0] gatedClk,
	output logic [clock_gate_pkg::SELECTOR_COUNT-1:0] selectorClk,
	output logic [QUAD_COUNT-1:0][QUAD_CLOCKS-1:0] quadClk
);

	// Pool: middle switch outputs first, fabric clock entry last
	localparam int POOL_N = SRC_COUNT + 1;
	// Central inputs: gated sources first, then the selectors
	localparam int CENTER_N = SRC_COUNT + clock_gate_pkg::SELECTOR_COUNT;

	// Every clock here is a waveform sampled by sys_clk, so each stage adds
	// whole cycles of latency; sources must stay well below half the system rate
	// or their phases are lost before any gate or selector sees them.

	// Pins arrive asynchronously; second stage is the only reader of the first
	logic [POOL_N-1:0] poolIn;
	logic [POOL_N-1:0] selPool;
	logic [SRC_COUNT-1:0] midSync;

	assign poolIn = {fabricClockEntry, midClk};

	for (genvar p = 0; p < POOL_N; p++) begin : g_sync
		logic meta_reg, meta_next;
		logic held_reg, held_next;

		always_comb begin
			meta_next = poolIn[p];
			held_next = meta_reg;
		end

		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				meta_reg <= 1'b0;
				held_reg <= 1'b0;
			end else begin
				meta_reg <= meta_next;
				held_reg <= held_next;
			end
		end

		assign selPool[p] = held_reg;
	end

	assign midSync = selPool[SRC_COUNT-1:0];

	// Quadrant gates, one per source path ahead of the central switch
	logic [SRC_COUNT-1:0] gated;

	for (genvar i = 0; i < SRC_COUNT; i++) begin : g_gate
		logic on_reg, on_next;
		logic out_reg, out_next;

		always_comb begin
			// Enable only moves while the source is low: no runt either way
			on_next = midSync[i] ? on_reg : gateEnable[i];
			out_next = midSync[i] & on_next;
		end

		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				on_reg <= 1'b0;
				out_reg <= clock_gate_pkg::RESET_LEVEL;
			end else begin
				on_reg <= on_next;
				out_reg <= out_next;
			end
		end

		assign gated[i] = out_reg;
	end

	// A disable never cuts a high phase short, at the cost of one phase of delay
	assign gatedClk = gated;

	// Dynamic clock selectors
	logic [clock_gate_pkg::SELECTOR_COUNT-1:0] selOut;

	for (genvar s = 0; s < clock_gate_pkg::SELECTOR_COUNT; s++) begin : g_sel
		clock_gate_pkg::selector_state_type state_reg, state_next;
		logic curPick_reg, curPick_next;
		logic out_reg, out_next;
		logic inA;
		logic inB;
		logic curClk;
		logic newClk;
		logic idleLevel;
		clock_gate_pkg::selector_cfg_type cfg;

		assign cfg = selCfg[s];
		// Out-of-range index reads as a stopped clock
		assign inA = (int'(cfg.srcA) < POOL_N) ? selPool[cfg.srcA] : 1'b0;
		assign inB = (int'(cfg.srcB) < POOL_N) ? selPool[cfg.srcB] : 1'b0;
		assign curClk = curPick_reg ? inB : inA;
		assign newClk = cfg.pick ? inB : inA;
		assign idleLevel = (cfg.mode == clock_gate_pkg::MODE_GLITCHLESS_HIGH);

		always_comb begin
			state_next = state_reg;
			curPick_next = curPick_reg;
			out_next = out_reg;
			if (cfg.mode == clock_gate_pkg::MODE_PLAIN_MUX) begin
				// No handshake, so stopped inputs cannot stall the switch
				curPick_next = cfg.pick;
				out_next = newClk;
				state_next = clock_gate_pkg::SEL_RUN;
			end else begin
				unique case (state_reg)
					clock_gate_pkg::SEL_RUN: begin
						out_next = curClk;
						if (cfg.pick != curPick_reg) begin
							state_next = clock_gate_pkg::SEL_DRAIN;
						end
					end
					clock_gate_pkg::SEL_DRAIN: begin
						// Old clock runs out its phase, then output parks
						if (curClk == idleLevel) begin
							out_next = idleLevel;
							state_next = clock_gate_pkg::SEL_HANDOVER;
						end else begin
							out_next = curClk;
						end
					end
					clock_gate_pkg::SEL_HANDOVER: begin
						// A new clock stopped away from the idle level waits here forever
						out_next = idleLevel;
						if (newClk == idleLevel) begin
							curPick_next = cfg.pick;
							state_next = clock_gate_pkg::SEL_RUN;
						end
					end
					default: begin
						// Illegal one-hot code: park the output and restart
						out_next = idleLevel;
						state_next = clock_gate_pkg::SEL_RUN;
					end
				endcase
			end
		end

		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				state_reg <= clock_gate_pkg::SEL_RUN;
				curPick_reg <= clock_gate_pkg::RESET_PICK;
				out_reg <= clock_gate_pkg::RESET_LEVEL;
			end else begin
				state_reg <= state_next;
				curPick_reg <= curPick_next;
				out_reg <= out_next;
			end
		end

		assign selOut[s] = out_reg;
	end

	assign selectorClk = selOut;

	// Central switch: each quadrant slot picks a gated source or a selector
	logic [CENTER_N-1:0] centerIn;

	assign centerIn = {selOut, gated};

	for (genvar q = 0; q < QUAD_COUNT; q++) begin : g_quad
		for (genvar c = 0; c < QUAD_CLOCKS; c++) begin : g_slot
			logic slot_reg, slot_next;

			always_comb begin
				// Unrouted slots stay parked low rather than pick a stray input
				if (int'(quadRoute[q][c]) < CENTER_N) begin
					slot_next = centerIn[quadRoute[q][c]];
				end else begin
					slot_next = 1'b0;
				end
			end

			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					slot_reg <= clock_gate_pkg::RESET_LEVEL;
				end else begin
					slot_reg <= slot_next;
				end
			end

			// Route changes take effect at once; a switch here may cut a phase
			assign quadClk[q][c] = slot_reg;
		end
	end

endmodule

`default_nettype wire

/* verification/clock_gate_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_gate_checker #(
	parameter int SRC_COUNT = 16,
	parameter int QUAD_COUNT = 4,
	parameter int QUAD_CLOCKS = 16
) (
	// System
	input wire logic sys_clk,
	input wire logic rst_b,
	// Block ports
	input wire logic [SRC_COUNT-1:0] midClk,
	input wire logic fabricClockEntry,
	input wire logic [SRC_COUNT-1:0] gateEnable,
	input wire clock_gate_pkg::selector_cfg_type [1:0] selCfg,
	input wire logic [QUAD_COUNT-1:0][QUAD_CLOCKS-1:0][4:0] quadRoute,
	input wire logic [SRC_COUNT-1:0] gatedClk,
	input wire logic [1:0] selectorClk,
	input wire logic [QUAD_COUNT-1:0][QUAD_CLOCKS-1:0] quadClk
);
	wire logic [SRC_COUNT:0] pool = {fabricClockEntry, midClk};
	wire logic [SRC_COUNT+1:0] center = {selectorClk, gatedClk};
	wire logic chosen = pool[selCfg[0].pick ? selCfg[0].srcB : selCfg[0].srcA];
	wire logic plain = selCfg[0].mode == clock_gate_pkg::MODE_PLAIN_MUX;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_off; !gateEnable[0] [*8] |-> !gatedClk[0]; endproperty
	a_off: assert property (p_off) else $error("gate moved while off");
	property p_src; gatedClk[0] |-> $past(midClk[0], 3); endproperty
	a_src: assert property (p_src) else $error("gate high without source");
	property p_runt; $rose(gatedClk[0]) |=> gatedClk[0]; endproperty
	a_runt: assert property (p_runt) else $error("gate runt pulse");
	property p_on; gateEnable[0] [*8] |-> gatedClk[0] == $past(midClk[0], 3); endproperty
	a_on: assert property (p_on) else $error("gate not following");
	property p_plain;
		(plain && $stable(selCfg[0])) [*4] |-> selectorClk[0] == $past(chosen, 3);
	endproperty
	a_plain: assert property (p_plain) else $error("mux output wrong");
	property p_hand; $changed(selCfg[0].pick) && !plain |-> ##20 selectorClk[0] == $past(chosen, 3);
	endproperty
	a_hand: assert property (p_hand) else $error("no handover");
	property p_low; $fell(selectorClk[0]) && !plain |=> !selectorClk[0]; endproperty
	a_low: assert property (p_low) else $error("selector glitch");
	property p_quad; quadClk[0][0] == $past(center[quadRoute[0][0]]); endproperty
	a_quad: assert property (p_quad) else $error("quadrant slot wrong");
endmodule
bind quadrant_clock_gate_and_select clock_gate_checker #(.SRC_COUNT(SRC_COUNT),
	.QUAD_COUNT(QUAD_COUNT), .QUAD_CLOCKS(QUAD_CLOCKS)) monitor (.sys_clk, .rst_b, .midClk,
	.fabricClockEntry, .gateEnable, .selCfg, .quadRoute, .gatedClk, .selectorClk, .quadClk);
`default_nettype wire

/* verification/fabric_clock_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fabric_clock_model (
	// Control
	input wire logic sys_clk,
	input wire logic stopLast,
	// Sources
	output logic [15:0] midClk,
	output logic fabricClockEntry
);
	logic [2:0] phase = 3'h0;
	// Free running, except midClk[15] while stopLast holds it high, so the plain mux can be checked passing a stopped clock
	always @(posedge sys_clk) phase <= #1 phase + 3'h1;
	always_comb begin
		for (int i = 0; i < 15; i++) midClk[i] = phase[1 + i % 2];
		midClk[15] = stopLast | phase[1];
		fabricClockEntry = phase[2];
	end
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic stopLast = 1'b0;
	logic [1:0] pSel = 2'h0;
	logic [1:0] seen = 2'h0;
	logic clearSeen = 1'b0;
	logic [15:0] midClk, gatedClk, gateEnable = 16'hffff;
	logic fabricClockEntry;
	clock_gate_pkg::selector_cfg_type [1:0] selCfg = '0;
	logic [3:0][15:0][4:0] quadRoute = '0;
	logic [1:0] selectorClk;
	logic [3:0][15:0] quadClk;
	int bad_count = 0;
	int checks = 0;
	wire logic probe = pSel[1] ? quadClk[0][0] : (pSel[0] ? selectorClk[0] : gatedClk[0]);
	fabric_clock_model model (.sys_clk, .stopLast, .midClk, .fabricClockEntry);
	quadrant_clock_gate_and_select DUT (.sys_clk, .rst_b, .midClk, .fabricClockEntry,
		.gateEnable, .selCfg, .quadRoute, .gatedClk, .selectorClk, .quadClk);
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) seen <= clearSeen ? 2'h0 : (seen | (probe ? 2'h2 : 2'h1));
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task check(input string what, input logic [1:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task watch(input int settle);
		step(settle);
		clearSeen = 1'b1;
		step(1);
		clearSeen = 1'b0;
		step(12);
	endtask
	task gate_scenario;
		gateEnable[0] = 1'b0;
		watch(8);
		check("gate off", 2'h1);
		gateEnable[0] = 1'b1;
		watch(8);
		check("gate on", 2'h3);
	endtask
	task plain_scenario;
		pSel = 2'h1;
		stopLast = 1'b1;
		selCfg[0] = {5'h0f, 5'h01, 1'b1, clock_gate_pkg::MODE_PLAIN_MUX};
		watch(6);
		check("plain", 2'h3);
		selCfg[0].pick = 1'b0;
		watch(6);
		check("stopped", 2'h2);
		stopLast = 1'b0;
	endtask
	task glitchless_scenario(input clock_gate_pkg::selector_mode_type mode);
		pSel = 2'h2;
		quadRoute[0][0] = 5'h10;
		selCfg[0] = {5'h00, 5'h10, selCfg[0].pick, mode};
		step(6);
		selCfg[0].pick = ~selCfg[0].pick;
		watch(25);
		check("handover", 2'h3);
		if (selCfg[0].pick) selCfg[0].srcA = 5'h1f;
		else selCfg[0].srcB = 5'h1f;
		watch(2);
		check("old source dropped", 2'h3);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		step(6);
		rst_b = 1'b1;
		gate_scenario();
		plain_scenario();
		glitchless_scenario(clock_gate_pkg::MODE_GLITCHLESS_LOW);
		glitchless_scenario(clock_gate_pkg::MODE_GLITCHLESS_HIGH);
		close_out();
	end
	initial begin
		#100000;
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire
